// ---- dv/spg_board_model.sv ----
// Purpose: Board logic wired to the eight spare pins
// Assumes: Device drive wins wherever its enable is high
// Notes:   Undriven pads show a random board level redrawn every traffic cycle
`timescale 1ns/1ps
module spg_board_model
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output      logic [7:0] pin_in
);
  // ==========================================================================
  // Pad resolution; a fresh board level exposes any stale sample
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : spg_board_model

// ---- dv/tb_spare_pin_gpio_port.sv ----
// Purpose: Self-checking bench for the spare pin port
// Assumes: Inputs change at the falling edge
// Notes:   Random traffic, both scan settings, reset in mid-run
`timescale 1ns/1ps
module tb_spare_pin_gpio_port
  import spg_pkg::*;
;
  logic       clk = 0, reset = 1, reg_write = 0, reg_read = 0, scan_active = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, func_out = 0, func_oe = 0, ext_level = 0;
  logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, m_en, m_val, samp, eff, x_oe, x_out;
  logic       clock_output_run, rd_pend = 0;
  logic [7:0] exp_q[$];
  int         bad_count = 0, n_tests = 0, seed = 32'haae7;

  always #2.5 clk = ~clk;

  spg_gpio_port i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .scan_active(scan_active), .func_out(func_out),
    .func_oe(func_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .clock_output_run(clock_output_run));
  spg_board_model i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));

  // ==========================================================================
  // Reference pads: scan mode hides the low nibble of the enables
  assign eff   = m_en & ~(scan_active ? SPG_SCAN_PIN_MASK : 8'h00);
  assign x_oe  = eff | func_oe;
  assign x_out = (eff & m_val) | (~eff & func_out);

  // Driver side notes each expected read; a same-edge write is not yet seen
  always @(posedge clk)
  begin
    rd_pend <= reg_read && !reset;
    if (reset)
    begin
      m_en  <= SPG_RST_PIN_OUTPUT_ENABLE;
      m_val <= SPG_RST_PIN_OUTPUT_VALUE;
      samp  <= SPG_RST_PIN_INPUT_SAMPLE;
    end
    else
    begin
      if (reg_read)
        exp_q.push_back(reg_addr == SPG_OFS_PIN_OUTPUT_ENABLE ? m_en :
          reg_addr == SPG_OFS_PIN_OUTPUT_VALUE ? m_val :
          reg_addr == SPG_OFS_PIN_INPUT_SAMPLE ? samp : SPG_RDATA_UNMAPPED);
      if (reg_write && reg_addr == SPG_OFS_PIN_OUTPUT_ENABLE)
        m_en <= reg_wdata;
      if (reg_write && reg_addr == SPG_OFS_PIN_OUTPUT_VALUE)
        m_val <= reg_wdata;
      samp <= (x_oe & x_out) | (~x_oe & ext_level);
    end
  end

  // Shared tally; every kind of result has its own compare task below
  task automatic tally(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : tally

  task automatic cmp_rdata(input logic [7:0] got, input logic [7:0] exp);
    tally("read data", got, exp);
  endtask : cmp_rdata

  task automatic cmp_oe(input logic [7:0] got, input logic [7:0] exp);
    tally("drive enables", got, exp);
  endtask : cmp_oe

  task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
    tally("pad levels", got, exp);
  endtask : cmp_out

  task automatic cmp_run(input logic got, input logic exp);
    tally("clock gate", {7'h00, got}, {7'h00, exp});
  endtask : cmp_run

  task automatic report_and_stop;
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Watcher: looks once the edge's updates have landed
  always @(posedge clk)
  begin
    #1;
    if (!reset)
    begin
      if (rd_pend)
        cmp_rdata(reg_rdata, exp_q.pop_front()); // Read data
      cmp_oe(pin_oe, x_oe); // Drive enables
      cmp_out(pin_out, x_out); // Pad levels
      cmp_run(clock_output_run, !m_en[SPG_BIT_CLOCK_OUT]); // Clock gate
    end
  end

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  // Random back-to-back traffic over 0x43..0x47, then a reset and scan mode on
  initial
  begin
    repeat (5) @(negedge clk);
    for (int ph = 0; ph < 2; ph++)
    begin
      reset       = 0;
      scan_active = ph[0];
      repeat (300)
      begin
        {reg_write, reg_read, reg_wdata, func_out} = 18'($random(seed));
        {func_oe, ext_level} = 16'($random(seed));
        reg_addr = 8'h43 + 8'({$random(seed)} % 5);
        @(negedge clk);
      end
      reg_write = 0;
      reg_read  = 0;
      reset     = 1;
      repeat (2) @(negedge clk);
    end
    report_and_stop();
  end
endmodule : tb_spare_pin_gpio_port

// ---- logic/spg_gpio_port.sv ----
// Purpose: Spare pin GPIO port with enable, output and input registers
// Assumes: Synchronous active-high reset, 200 MHz clk, pins synchronous
// Notes:   Pads are a plain mux behind three byte registers; input reads
//          lag the pins by one clock because of the sample flop
`timescale 1ns/1ps
module spg_gpio_port
  import spg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  // Host register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_wdata,
  output      logic [7:0] reg_rdata,
  // Nonvolatile boundary scan activation
  input  wire logic       scan_active,
  // Dedicated functions of the pins
  input  wire logic [7:0] func_out,
  input  wire logic [7:0] func_oe,
  // Pads
  input  wire logic [7:0] pin_in,
  output      logic [7:0] pin_out,
  output      logic [7:0] pin_oe,
  // Gate for the clock output generator
  output      logic       clock_output_run
);

  // ==========================================================================
  // Registers
  logic [7:0] pin_output_enable_q;
  logic [7:0] pin_output_value_q;
  logic [7:0] pin_input_sample_q;
  logic [7:0] sw_enable;
  logic [7:0] func_oe_gated;

  // Address decode used for writes and reads
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  // Enable register write
  always_ff @(posedge clk)
  begin
    if (reset)
      pin_output_enable_q <= SPG_RST_PIN_OUTPUT_ENABLE;
    else if (reg_write && addr_hit(reg_addr, SPG_OFS_PIN_OUTPUT_ENABLE))
      pin_output_enable_q <= reg_wdata;
  end

  // Output level register write
  always_ff @(posedge clk)
  begin
    if (reset)
      pin_output_value_q <= SPG_RST_PIN_OUTPUT_VALUE;
    else if (reg_write && addr_hit(reg_addr, SPG_OFS_PIN_OUTPUT_VALUE))
      pin_output_value_q <= reg_wdata;
  end

  // Input sample: pins are already synchronous, one stage keeps reads clean
  always_ff @(posedge clk)
  begin
    if (reset)
      pin_input_sample_q <= SPG_RST_PIN_INPUT_SAMPLE;
    else
      pin_input_sample_q <= pin_in;
  end

  // Read data comes from a flop; writes to the input register are dropped
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= SPG_RDATA_UNMAPPED;
    else if (reg_read)
    begin
      if (addr_hit(reg_addr, SPG_OFS_PIN_OUTPUT_ENABLE))
        reg_rdata <= pin_output_enable_q;
      else if (addr_hit(reg_addr, SPG_OFS_PIN_OUTPUT_VALUE))
        reg_rdata <= pin_output_value_q;
      else if (addr_hit(reg_addr, SPG_OFS_PIN_INPUT_SAMPLE))
        reg_rdata <= pin_input_sample_q;
      else
        reg_rdata <= SPG_RDATA_UNMAPPED;
    end
  end

  // ==========================================================================
  // Effective enables
  // Scan mode keeps the test pins: stored bits stay readable but do nothing
  always_comb
  begin
    sw_enable = pin_output_enable_q;
    if (scan_active)
      sw_enable = pin_output_enable_q & ~SPG_SCAN_PIN_MASK;
  end

  // Clock output stops while its pin is under software control
  assign clock_output_run = ~pin_output_enable_q[SPG_BIT_CLOCK_OUT];

  // ==========================================================================
  // Dedicated drive gating
  // A stopped clock generator must not keep asking for its pad; dropping the
  // request here means the pad cell never sees a stale drive from that path
  always_comb
  begin
    func_oe_gated = func_oe;
    if (!clock_output_run)
      func_oe_gated[SPG_BIT_CLOCK_OUT] = 1'b0;
  end

  // ==========================================================================
  // Pad cells
  genvar gi;
  generate
    for (gi = 0; gi < SPG_PIN_COUNT; gi++)
    begin : g_pin
      // Cleared enable hands the pad back to its dedicated function
      spg_pin_cell u_cell
      (
        .sw_enable (sw_enable[gi]),
        .sw_level  (pin_output_value_q[gi]),
        .func_out  (func_out[gi]),
        .func_oe   (func_oe_gated[gi]),
        .pad_out   (pin_out[gi]),
        .pad_oe    (pin_oe[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Checks
  // Register reads are checked one clock after the request, when data stands
  AST_SIGNAL_IN_DRIVE: assert property (@(posedge clk) disable iff (reset)
    pin_output_enable_q[SPG_BIT_SIGNAL_IN] |->
      pin_oe[SPG_BIT_SIGNAL_IN] && pin_out[SPG_BIT_SIGNAL_IN] ==
      pin_output_value_q[SPG_BIT_SIGNAL_IN])
    else $error("signal input pin not driven while enabled");

  AST_CLOCK_OUT_OFF: assert property (@(posedge clk) disable iff (reset)
    pin_output_enable_q[SPG_BIT_CLOCK_OUT] |-> !clock_output_run &&
      pin_oe[SPG_BIT_CLOCK_OUT])
    else $error("clock output still running under software control");

  AST_IFSEL_DRIVE: assert property (@(posedge clk) disable iff (reset)
    (reg_write && reg_addr == SPG_OFS_PIN_OUTPUT_ENABLE &&
      reg_wdata[SPG_BIT_IFSEL_HI] && reg_wdata[SPG_BIT_IFSEL_LO]) |=>
      pin_oe[SPG_BIT_IFSEL_HI] && pin_oe[SPG_BIT_IFSEL_LO])
    else $error("interface select pins not driven after enable write");

  AST_SCAN_DRIVE: assert property (@(posedge clk) disable iff (reset)
    (!scan_active && pin_output_enable_q[SPG_BIT_TCK]) |-> pin_oe[SPG_BIT_TCK] &&
      pin_out[SPG_BIT_TCK] == pin_output_value_q[SPG_BIT_TCK])
    else $error("TCK pin not driven while enabled");

  AST_SCAN_MASK: assert property (@(posedge clk) disable iff (reset)
    scan_active |-> (pin_oe & SPG_SCAN_PIN_MASK) == (func_oe & SPG_SCAN_PIN_MASK))
    else $error("scan pins taken over during boundary scan");

  AST_OUT_LEVEL: assert property (@(posedge clk) disable iff (reset)
    (reg_write && reg_addr == SPG_OFS_PIN_OUTPUT_VALUE) |=>
      ((pin_out ^ $past(reg_wdata)) & sw_enable) == 8'h00)
    else $error("pin levels do not follow output register");

  AST_IN_READ: assert property (@(posedge clk) disable iff (reset)
    (reg_read && reg_addr == SPG_OFS_PIN_INPUT_SAMPLE && !$past(reset)) |=>
      reg_rdata == $past(pin_in, 2))
    else $error("input register read does not show pin state");

  AST_RELEASE: assert property (@(posedge clk) disable iff (reset)
    (pin_output_enable_q == 8'h00) |-> pin_oe == func_oe && pin_out == func_out)
    else $error("pad not returned to dedicated function");

  // Test pins outside boundary scan behave like any other spare pin
  AST_SCAN_PINS: assert property (@(posedge clk) disable iff (reset)
    !scan_active |->
      (pin_output_enable_q & SPG_SCAN_PIN_MASK & ~pin_oe) == 8'h00 &&
      ((pin_out ^ pin_output_value_q) & pin_output_enable_q & SPG_SCAN_PIN_MASK) == 8'h00)
    else $error("scan pins not driven while enabled outside boundary scan");

  AST_SCAN_LEVEL: assert property (@(posedge clk) disable iff (reset)
    scan_active |-> (pin_out & SPG_SCAN_PIN_MASK) == (func_out & SPG_SCAN_PIN_MASK))
    else $error("scan pin levels taken over during boundary scan");

  AST_CLOCK_OUT_FREE: assert property (@(posedge clk) disable iff (reset)
    !pin_output_enable_q[SPG_BIT_CLOCK_OUT] |-> clock_output_run &&
      pin_oe[SPG_BIT_CLOCK_OUT] == func_oe[SPG_BIT_CLOCK_OUT] &&
      pin_out[SPG_BIT_CLOCK_OUT] == func_out[SPG_BIT_CLOCK_OUT])
    else $error("clock output pin not returned to its clock function");

  // Register readback and write protection
  AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (reset)
    (reg_write && reg_addr == SPG_OFS_PIN_OUTPUT_ENABLE) |=>
      pin_output_enable_q == $past(reg_wdata))
    else $error("enable register write lost");

  // Stored scan enables stay visible even while boundary scan ignores them
  AST_ENABLE_READ: assert property (@(posedge clk) disable iff (reset)
    (reg_read && reg_addr == SPG_OFS_PIN_OUTPUT_ENABLE) |=>
      reg_rdata == $past(pin_output_enable_q))
    else $error("enable register read back wrong value");

  AST_VALUE_READ: assert property (@(posedge clk) disable iff (reset)
    (reg_read && reg_addr == SPG_OFS_PIN_OUTPUT_VALUE) |=>
      reg_rdata == $past(pin_output_value_q))
    else $error("output register read back wrong value");

  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (reset)
    (reg_read && reg_addr != SPG_OFS_PIN_OUTPUT_ENABLE &&
      reg_addr != SPG_OFS_PIN_OUTPUT_VALUE && reg_addr != SPG_OFS_PIN_INPUT_SAMPLE) |=>
      reg_rdata == SPG_RDATA_UNMAPPED)
    else $error("unmapped read returned data");

  AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (reset)
    !reg_read |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  AST_SAMPLE_TRACK: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> pin_input_sample_q == $past(pin_in))
    else $error("input sample does not follow the pins");

  // The input register is read only; a write there must touch nothing
  AST_INPUT_READ_ONLY: assert property (@(posedge clk) disable iff (reset)
    (reg_write && reg_addr == SPG_OFS_PIN_INPUT_SAMPLE) |=>
      $stable(pin_output_enable_q) && $stable(pin_output_value_q))
    else $error("write to input register changed a control register");

endmodule : spg_gpio_port

// ---- logic/spg_pin_cell.sv ----
// Purpose: One spare pin: chooses dedicated function or software I/O
// Assumes: Enable already qualified by the caller
// Notes:   Purely combinational pad mux
`timescale 1ns/1ps
module spg_pin_cell
(
  input  wire logic sw_enable,
  input  wire logic sw_level,
  input  wire logic func_out,
  input  wire logic func_oe,
  output      logic pad_out,
  output      logic pad_oe
);

  // ==========================================================================
  // Pad mux
  // Software takes the pad only while enabled, else the dedicated path owns it
  always_comb
  begin
    pad_out = sw_enable ? sw_level : func_out;
    pad_oe  = sw_enable ? 1'b1     : func_oe;
  end

endmodule : spg_pin_cell

// ---- logic/spg_pkg.sv ----
// Purpose: Shared constants for the spare pin I/O port
// Assumes: Byte-wide host register port, eight spare pins
// Notes:   Bit positions follow the pin enable register layout
package spg_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] SPG_OFS_PIN_OUTPUT_ENABLE = 8'h44;
  localparam logic [7:0] SPG_OFS_PIN_OUTPUT_VALUE  = 8'h45;
  localparam logic [7:0] SPG_OFS_PIN_INPUT_SAMPLE  = 8'h46;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SPG_RST_PIN_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0] SPG_RST_PIN_OUTPUT_VALUE  = 8'h00;
  localparam logic [7:0] SPG_RST_PIN_INPUT_SAMPLE  = 8'h00;
  localparam logic [7:0] SPG_RDATA_UNMAPPED        = 8'h00;

  // ==========================================================================
  // Pin bit positions
  localparam int SPG_PIN_COUNT      = 8;
  localparam int SPG_BIT_SIGNAL_IN  = 7;
  localparam int SPG_BIT_CLOCK_OUT  = 6;
  localparam int SPG_BIT_IFSEL_HI   = 5;
  localparam int SPG_BIT_IFSEL_LO   = 4;
  localparam int SPG_BIT_TCK        = 3;
  localparam int SPG_BIT_TDI        = 2;
  localparam int SPG_BIT_TDO        = 1;
  localparam int SPG_BIT_TMS        = 0;

  // Boundary scan pins occupy the low nibble
  localparam logic [7:0] SPG_SCAN_PIN_MASK = 8'h0F;

endpackage : spg_pkg
